// ===== rtl/ihp_dev.sv
`default_nettype none
module ihp_dev #(
  parameter int RST_OUT_CYCLES = ihp_pkg::RST_PULSE_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  ihp_if.dev pins,
  input wire logic strobe_mode,
  input wire logic term_en,
  input wire logic wake_reset_en,
  input wire logic irq_pending,
  input wire logic [7:0] reg_rdata,
  output logic reg_rd,
  output logic reg_wr,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic muxed,
  output logic in_reset,
  output logic wake_irq
);
  typedef struct packed {
    logic [19:0] s1;
    logic [19:0] s2;
    logic [19:0] s3;
    logic [19:0] f;
    logic sep;
    logic muxed;
    logic [5:0] addr;
    logic active;
    logic is_rd;
    logic [7:0] wdata;
    logic [7:0] dout;
    logic bus_oe;
    logic reg_rd;
    logic reg_wr;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic int_oe;
    logic in_reset;
    logic wake_q;
    logic wake_irq;
    logic rst_oe;
    logic [23:0] rst_cnt;
  } ihp_dev_s;
  ihp_dev_s q, n;
  logic [19:0] raw;
  logic sel;
  logic strobe;
  logic rd_dir;
  logic act;
  logic wake_fall;

  assign raw = {pins.wake_n, pins.rst, pins.ale, pins.strobe_rd, pins.rw_wr, pins.cs_n,
                pins.addr, pins.bus};

  // One pin sample gives the access strobe (upper bit) and the read direction.
  function automatic logic [1:0] decode_strobe(input logic sep, input logic stb_n,
                                               input logic rw);
    logic [1:0] res;
    res = 2'h0;
    if (sep == ihp_pkg::STROBE_SEP) begin
      res = {~stb_n | ~rw, ~stb_n}; // RULE_06
    end else begin
      res = {~stb_n, rw}; // RULE_04
    end
    return res;
  endfunction

  // Drops every piece of bus access state; the outgoing reset pulse is kept,
  // otherwise a self-generated reset would cut itself short.
  function automatic ihp_dev_s pin_cleared(input ihp_dev_s s);
    ihp_dev_s c;
    c = s;
    c.muxed = 1'b0;
    c.active = 1'b0;
    c.is_rd = 1'b0;
    c.bus_oe = 1'b0;
    c.reg_rd = 1'b0;
    c.reg_wr = 1'b0;
    c.int_oe = 1'b0;
    c.addr = 6'h00;
    c.reg_addr = 6'h00;
    c.reg_wdata = 8'h00;
    c.wdata = 8'h00;
    c.dout = 8'h00;
    return c;
  endfunction

  always_comb begin
    sel = ~q.f[ihp_pkg::DP_CS]; // RULE_03
    {strobe, rd_dir} = decode_strobe(q.sep, q.f[ihp_pkg::DP_STB], q.f[ihp_pkg::DP_RW]);
    act = sel & strobe; // RULE_03
    // The edge is taken from the filtered level, so a short glitch cannot raise it.
    wake_fall = q.wake_q & ~q.f[ihp_pkg::DP_WAKE];
  end

  always_comb begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f = 20'(ihp_pkg::filt(32'(q.s2), 32'(q.s3), 32'(q.f)));
    n.reg_rd = 1'b0;
    n.reg_wr = 1'b0;
    n.wake_irq = 1'b0;
    n.wake_q = q.f[ihp_pkg::DP_WAKE];

    // The convention is reloaded only between accesses, so a change of the mode
    // input can never flip the meaning of a strobe that is already running.
    if (!act && !q.active) begin
      n.sep = strobe_mode; // RULE_15
    end

    // Any latch enable pulse switches the port to the shared-bus type.
    if (q.f[ihp_pkg::DP_ALE]) begin
      n.muxed = 1'b1; // RULE_09
      n.addr = q.f[ihp_pkg::DP_BUS +: 6]; // RULE_08
    end

    n.active = act;
    if (act && !q.active) begin
      n.is_rd = rd_dir;
      n.reg_rd = rd_dir;
      if (q.muxed) begin
        n.reg_addr = q.addr; // RULE_01
      end else begin
        n.reg_addr = q.f[ihp_pkg::DP_ADDR +: 6]; // RULE_02
      end
    end

    // Write data is tracked through the strobe so the last settled value wins.
    if (act) begin
      n.wdata = q.f[ihp_pkg::DP_BUS +: 8];
    end

    // Read data is taken once, with the read pulse, and held until the strobe ends.
    if (q.reg_rd) begin
      n.dout = reg_rdata;
      n.bus_oe = q.active;
    end

    if (!act && q.active) begin
      n.bus_oe = 1'b0; // RULE_05
      if (!q.is_rd) begin
        n.reg_wr = 1'b1; // RULE_05
        n.reg_wdata = q.wdata;
      end
    end

    n.int_oe = irq_pending; // RULE_07

    if (term_en && wake_fall) begin
      n.wake_irq = 1'b1; // RULE_13
      if (wake_reset_en && !q.rst_oe) begin
        n.rst_oe = 1'b1; // RULE_12
        n.rst_cnt = 24'(RST_OUT_CYCLES - 1);
      end
    end

    // A running pulse ignores further wake edges, so its length stays fixed.
    if (q.rst_oe) begin
      if (q.rst_cnt == 24'h00_0000) begin
        n.rst_oe = 1'b0;
      end else begin
        n.rst_cnt = q.rst_cnt - 24'h00_0001;
      end
    end

    n.in_reset = q.f[ihp_pkg::DP_RST]; // RULE_10
    if (q.f[ihp_pkg::DP_RST]) begin
      n = pin_cleared(n); // RULE_10
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      // Reset values are the idle pin levels, so no false edge follows reset.
      q.s1 <= 20'h9_C0FF;
      q.s2 <= 20'h9_C0FF;
      q.s3 <= 20'h9_C0FF;
      q.f <= 20'h9_C0FF;
      q.wake_q <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign pins.bus_d_o = q.dout;
  assign pins.bus_d_oe = q.bus_oe;
  // The interrupt pin is only ever pulled low; the pull-up gives its idle level.
  assign pins.int_d_o = 1'b0; // RULE_07
  assign pins.int_d_oe = q.int_oe; // RULE_07
  assign pins.rst_d_o = q.rst_oe;
  assign pins.rst_d_oe = q.rst_oe; // RULE_12
  assign reg_rd = q.reg_rd;
  assign reg_wr = q.reg_wr;
  assign reg_addr = q.reg_addr;
  assign reg_wdata = q.reg_wdata;
  assign muxed = q.muxed;
  assign in_reset = q.in_reset;
  assign wake_irq = q.wake_irq;
endmodule
`default_nettype wire

// ===== rtl/ihp_host.sv
`default_nettype none
module ihp_host #(
  parameter int RST_OUT_CYCLES = ihp_pkg::RST_PULSE_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  ihp_if.host pins,
  input wire logic mux_mode,
  input wire logic strobe_mode,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [5:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  input wire logic reset_req,
  input wire logic wake_n_req,
  output logic irq,
  output logic dev_reset
);
  typedef struct packed {
    logic [9:0] s1, s2, s3, f;
    ihp_pkg::ihp_state_e st;
    logic [7:0] cnt;
    logic write;
    logic [7:0] wdata;
    logic [5:0] addr;
    logic ale, cs_n, rw_wr, strobe_rd, bus_oe;
    logic [7:0] bus_o;
    logic [7:0] rdata;
    logic rsp_valid, cmd_ready, irq, dev_reset, rst_o, wake_n;
    logic [23:0] rst_cnt;
  } ihp_host_s;
  ihp_host_s q, n;
  logic [9:0] raw;
  logic done;
  localparam logic [7:0] PH = 8'(ihp_pkg::PHASE_CYC - 1);

  assign raw = {pins.rst, pins.int_n, pins.bus};
  assign done = (q.cnt == 8'h00);

  always_comb begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f = 10'(ihp_pkg::filt(32'(q.s2), 32'(q.s3), 32'(q.f)));
    n.irq = ~q.f[ihp_pkg::HS_INT];
    n.dev_reset = q.f[ihp_pkg::HS_RST];
    n.wake_n = wake_n_req;
    n.rsp_valid = 1'b0;
    if (!done) begin
      n.cnt = q.cnt - 8'h01;
    end
    case (q.st)
      ihp_pkg::IHP_IDLE: begin
        if (cmd_valid && q.cmd_ready && !q.rst_o) begin
          n.cmd_ready = 1'b0;
          n.write = cmd_write;
          n.wdata = cmd_wdata;
          n.cnt = PH;
          if (mux_mode) begin
            n.ale = 1'b1; // RULE_08
            n.bus_o = {2'b00, cmd_addr}; // RULE_01
            n.bus_oe = 1'b1;
            n.st = ihp_pkg::IHP_ADDR;
          end else begin
            n.addr = cmd_addr; // RULE_14
            n.st = ihp_pkg::IHP_SETUP;
          end
        end
      end
      ihp_pkg::IHP_ADDR: begin
        if (done) begin
          n.ale = 1'b0;
          n.bus_oe = 1'b0;
          n.cnt = PH;
          n.st = ihp_pkg::IHP_SETUP;
        end
      end
      ihp_pkg::IHP_SETUP: begin
        n.cs_n = 1'b0; // RULE_03
        n.rw_wr = (strobe_mode == ihp_pkg::STROBE_DIR) ? ~q.write : 1'b1; // RULE_04
        n.bus_o = q.wdata; // RULE_02
        n.bus_oe = q.write;
        if (done) begin
          n.cnt = PH;
          n.st = ihp_pkg::IHP_STROBE;
          if (strobe_mode == ihp_pkg::STROBE_SEP && q.write) begin
            n.rw_wr = 1'b0; // RULE_06
          end else begin
            n.strobe_rd = 1'b0;
          end
        end
      end
      ihp_pkg::IHP_STROBE: begin
        if (done) begin
          n.rdata = q.f[7:0];
          n.strobe_rd = 1'b1; // RULE_05
          n.rw_wr = 1'b1;
          n.cnt = PH;
          n.st = ihp_pkg::IHP_HOLD;
        end
      end
      ihp_pkg::IHP_HOLD: begin
        if (done) begin
          n.cs_n = 1'b1;
          n.bus_oe = 1'b0;
          n.rsp_valid = 1'b1;
          n.cnt = PH;
          n.st = ihp_pkg::IHP_GAP;
        end
      end
      ihp_pkg::IHP_GAP: begin
        if (done) begin
          n.cmd_ready = 1'b1;
          n.st = ihp_pkg::IHP_IDLE;
        end
      end
      default: begin
        n.st = ihp_pkg::IHP_IDLE;
      end
    endcase
    if (q.rst_o) begin
      if (q.rst_cnt == 24'h00_0000) begin
        n.rst_o = 1'b0;
      end else begin
        n.rst_cnt = q.rst_cnt - 24'h00_0001;
      end
    end else if (reset_req) begin
      n.rst_o = 1'b1; // RULE_11
      n.rst_cnt = 24'(RST_OUT_CYCLES - 1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      // Reset values are the idle pin levels, so no false reset is seen after reset.
      q.s1 <= 10'h1FF;
      q.s2 <= 10'h1FF;
      q.s3 <= 10'h1FF;
      q.f <= 10'h1FF;
      q.st <= ihp_pkg::IHP_IDLE;
      q.cs_n <= 1'b1;
      q.rw_wr <= 1'b1;
      q.strobe_rd <= 1'b1;
      q.cmd_ready <= 1'b1;
      q.wake_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign pins.bus_h_o = q.bus_o;
  assign pins.bus_h_oe = q.bus_oe;
  assign pins.addr = q.addr;
  assign pins.cs_n = q.cs_n;
  assign pins.rw_wr = q.rw_wr;
  assign pins.strobe_rd = q.strobe_rd;
  assign pins.ale = q.ale;
  assign pins.rst_h_o = q.rst_o;
  assign pins.wake_n = q.wake_n;
  assign cmd_ready = q.cmd_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rdata;
  assign irq = q.irq;
  assign dev_reset = q.dev_reset;
endmodule
`default_nettype wire

// ===== rtl/ihp_if.sv
`default_nettype none
interface ihp_if;
  logic [7:0] bus_h_o;
  logic bus_h_oe;
  logic [7:0] bus_d_o;
  logic bus_d_oe;
  logic [7:0] bus;
  logic [5:0] addr;
  logic cs_n;
  logic rw_wr;
  logic strobe_rd;
  logic ale;
  logic int_d_o;
  logic int_d_oe;
  logic int_n;
  logic rst_h_o;
  logic rst_d_o;
  logic rst_d_oe;
  logic rst;
  logic wake_n;

  // Pull-ups on the data bus and interrupt, pull-down on the reset line.
  assign bus = bus_d_oe ? bus_d_o : (bus_h_oe ? bus_h_o : 8'hFF);
  assign int_n = int_d_oe ? int_d_o : 1'b1;
  assign rst = rst_h_o | (rst_d_oe & rst_d_o);

  modport dev (input bus, addr, cs_n, rw_wr, strobe_rd, ale, rst, wake_n,
               output bus_d_o, bus_d_oe, int_d_o, int_d_oe, rst_d_o, rst_d_oe);
  modport host (input bus, int_n, rst,
                output bus_h_o, bus_h_oe, addr, cs_n, rw_wr, strobe_rd, ale, rst_h_o, wake_n);
endinterface
`default_nettype wire

// ===== rtl/ihp_pkg.sv
// Contract
// (RULE_01) Muxed bus: address first, then data.
// (RULE_02) Non-muxed bus: data only, address separate.
// (RULE_03) Accesses only while chip select low.
// (RULE_04) Direction high is read, low write.
// (RULE_05) Strobe rising edge completes the access.
// (RULE_06) Separate strobes: active strobe gives direction.
// (RULE_07) Interrupt open drain, low while pending.
// (RULE_08) Address captured while latch enable high.
// (RULE_09) Latch enable selects muxed or non-muxed.
// (RULE_10) Reset pin high holds device in reset.
// (RULE_11) External reset lasts at least four ms.
// (RULE_12) Terminal mode may drive reset pin out.
// (RULE_13) Wake falling edge: interrupt, optional reset.
// (RULE_14) Non-muxed address on dedicated lines, bit 0 up.
// (RULE_15) Strobe convention is static configuration.
`default_nettype none
package ihp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int CLK_KHZ = 125000;
  localparam int RST_PULSE_MS = 4;
  localparam int RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;
  localparam int PHASE_CYC = 12;
  localparam logic STROBE_DIR = 1'b0;
  localparam logic STROBE_SEP = 1'b1;
  localparam int DP_BUS = 0;
  localparam int DP_ADDR = 8;
  localparam int DP_CS = 14;
  localparam int DP_RW = 15;
  localparam int DP_STB = 16;
  localparam int DP_ALE = 17;
  localparam int DP_RST = 18;
  localparam int DP_WAKE = 19;
  localparam int DP_W = 20;
  localparam int HS_BUS = 0;
  localparam int HS_INT = 8;
  localparam int HS_RST = 9;
  localparam int HS_W = 10;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'h00;

  typedef enum logic [5:0] {
    IHP_IDLE = 6'b00_0001,
    IHP_ADDR = 6'b00_0010,
    IHP_SETUP = 6'b00_0100,
    IHP_STROBE = 6'b00_1000,
    IHP_HOLD = 6'b01_0000,
    IHP_GAP = 6'b10_0000
  } ihp_state_e;

  // A bit changes only once the second and third stages agree.
  function automatic logic [31:0] filt(input logic [31:0] s2, input logic [31:0] s3,
                                       input logic [31:0] f);
    filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
  endfunction
endpackage
`default_nettype wire

// ===== verification/ihp_chk.sv
`default_nettype none
module ihp_chk #(
  parameter int RST_OUT_CYCLES = 20
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] bus_h_o,
  input wire logic bus_h_oe,
  input wire logic bus_d_oe,
  input wire logic cs_n,
  input wire logic rw_wr,
  input wire logic strobe_rd,
  input wire logic ale,
  input wire logic int_d_o,
  input wire logic int_d_oe,
  input wire logic rst_h_o,
  input wire logic rst_d_oe,
  input wire logic rst
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_irq_open_drain: assert property (int_d_oe |-> !int_d_o)
    else $error("interrupt line driven high");
  a_dev_drive_select: assert property (bus_d_oe |-> !cs_n)
    else $error("device drives bus while not selected");
  a_dev_drive_read: assert property (bus_d_oe |-> rw_wr && !bus_h_oe)
    else $error("device drives bus outside a read");
  a_addr_phase_drive: assert property (ale |-> bus_h_oe && cs_n)
    else $error("address phase without address on bus");
  a_strobe_select: assert property (!strobe_rd |-> !cs_n)
    else $error("strobe without chip select");
  a_strobe_width: assert property ($fell(strobe_rd) |-> ##12 $rose(strobe_rd))
    else $error("strobe phase length wrong");
  a_write_data_hold: assert property (!strobe_rd && bus_h_oe |=> $stable(bus_h_o))
    else $error("host data moved during strobe");
  a_pin_clears_bus: assert property (rst [*8] |-> !bus_d_oe)
    else $error("device drives bus while held in reset");
  // The pulse end is only bounded, so a long pulse from a wrong count still fails.
  a_dev_reset_pulse: assert property ($rose(rst_d_oe) |->
    (rst_d_oe && rst) [*8] ##[1:RST_OUT_CYCLES] !rst_d_oe)
    else $error("device reset pulse length wrong");
  a_host_reset_pulse: assert property ($rose(rst_h_o) |->
    rst_h_o [*8] ##[1:RST_OUT_CYCLES] !rst_h_o)
    else $error("host reset pulse length wrong");

  c_muxed_access: cover property ($fell(ale));
  c_read_drive: cover property ($rose(bus_d_oe));
  c_wake_reset: cover property ($rose(rst_d_oe));
  c_host_reset: cover property ($rose(rst_h_o));
endmodule
`default_nettype wire

// ===== verification/test_isdn_ctrl_host_bus_port.sv
`default_nettype none
module test_isdn_ctrl_host_bus_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RST_CYC = 20;
  logic clock = 0, reset_n = 0, mux_mode = 0, strobe_mode = 0;
  logic cmd_valid = 0, cmd_write = 0, cmd_ready, rsp_valid, reset_req = 0, wake_n_req = 1;
  logic [5:0] cmd_addr = 0, reg_addr, wa;
  logic [7:0] cmd_wdata = 0, rsp_rdata, reg_rdata = 0, reg_wdata, wd;
  logic irq, dev_reset, term_en = 0, wake_reset_en = 0, irq_pending = 0;
  logic reg_rd, reg_wr, muxed, in_reset, wake_irq;
  int fail_count = 0, checks = 0, seed = 90589, nwr, nrd, nwk, nrs;

  ihp_if ihp_if_inst ();
  ihp_host #(.RST_OUT_CYCLES(RST_CYC)) ihp_host_inst (.clock(clock), .reset_n(reset_n),
    .pins(ihp_if_inst), .mux_mode(mux_mode), .strobe_mode(strobe_mode),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .reset_req(reset_req), .wake_n_req(wake_n_req), .irq(irq),
    .dev_reset(dev_reset));
  ihp_dev #(.RST_OUT_CYCLES(RST_CYC)) ihp_dev_inst (.clock(clock), .reset_n(reset_n),
    .pins(ihp_if_inst), .strobe_mode(strobe_mode), .term_en(term_en),
    .wake_reset_en(wake_reset_en), .irq_pending(irq_pending), .reg_rdata(reg_rdata),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .muxed(muxed), .in_reset(in_reset), .wake_irq(wake_irq));
  ihp_chk #(.RST_OUT_CYCLES(RST_CYC)) ihp_chk_inst (.clock(clock), .reset_n(reset_n),
    .bus_h_o(ihp_if_inst.bus_h_o), .bus_h_oe(ihp_if_inst.bus_h_oe),
    .bus_d_oe(ihp_if_inst.bus_d_oe), .cs_n(ihp_if_inst.cs_n), .rw_wr(ihp_if_inst.rw_wr),
    .strobe_rd(ihp_if_inst.strobe_rd), .ale(ihp_if_inst.ale), .int_d_o(ihp_if_inst.int_d_o),
    .int_d_oe(ihp_if_inst.int_d_oe), .rst_h_o(ihp_if_inst.rst_h_o),
    .rst_d_oe(ihp_if_inst.rst_d_oe), .rst(ihp_if_inst.rst));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The register file model answers a read with the inverse of the stimulus byte.
  function automatic logic [7:0] reg_answer(input logic [7:0] d);
    return ~d;
  endfunction

  // One host command; the device side event counts and payload are gathered meanwhile.
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
    int i;
    nwr = 0;
    nrd = 0;
    wa = 'x;
    wd = 'x;
    for (i = 0; i < 200 && !cmd_ready; i++) tick(1);
    check("ready", cmd_ready, 1);
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
    reg_rdata = reg_answer(d);
    tick(1);
    cmd_valid = 0;
    for (i = 0; i < 200 && !rsp_valid; i++) begin
      if (reg_wr) begin
        nwr++;
        wa = reg_addr;
        wd = reg_wdata;
      end
      if (reg_rd) begin
        nrd++;
        tick(1);
        wa = reg_addr;
      end
      tick(1);
    end
    check("response", i < 200, 1);
    check("write count", nwr, w);
    check("read count", nrd, !w);
    check("address", wa, a);
    if (w) check("write data", wd, d);
    else check("read data", rsp_rdata, reg_answer(d));
  endtask

  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end

  initial begin
    int m, k;
    logic [5:0] a;
    logic [7:0] d;
    // Modes only change under reset, since the strobe convention is static.
    for (m = 0; m < 4; m++) begin
      {mux_mode, strobe_mode} = 2'(m);
      reset_n = 0;
      tick(3);
      reset_n = 1;
      tick(5);
      for (k = 0; k < 8; k++) begin
        a = (k < 2) ? {6{k[0]}} : 6'($random(seed));
        d = (k < 2) ? {8{k[0]}} : 8'($random(seed));
        access(k[0] ^ k[1], a, d);
      end
      check("muxed", muxed, mux_mode);
    end
    reset_req = 1;
    tick(1);
    reset_req = 0;
    tick(10);
    check("in reset", in_reset, 1);
    check("host sees reset", dev_reset, 1);
    tick(30);
    check("reset over", in_reset, 0);
    check("muxed cleared", muxed, 0);
    for (k = 0; k < 4; k++) begin
      irq_pending = k[0];
      tick(10);
      check("irq", irq, k[0]);
    end
    for (k = 0; k < 3; k++) begin
      {term_en, wake_reset_en} = {k > 0, k > 1};
      nwk = 0;
      nrs = 0;
      wake_n_req = 0;
      for (m = 0; m < 60; m++) begin
        nwk += wake_irq;
        nrs += dev_reset;
        tick(1);
        if (m == 10) wake_n_req = 1;
      end
      check("wake irq", nwk, k > 0);
      check("wake reset", nrs > 0, k > 1);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
